// ===== rnc_pkg.sv
package rnc_pkg;

  // register numbers as addressed by the host command
  localparam logic [7:0] REG_UNIT_ID = 8'h69;
  localparam logic [7:0] REG_TX_POWER = 8'h6c;
  localparam logic [7:0] REG_FRAMING = 8'h6e;
  localparam logic [7:0] REG_RETRANS = 8'h71;
  localparam logic [7:0] REG_REP_POS = 8'h72;
  localparam logic [7:0] REG_SYNC_ADDR = 8'h76;
  localparam logic [7:0] REG_UP_LEVEL = 8'h7b;
  localparam logic [7:0] REG_DOWN_LEVEL = 8'h7c;
  localparam logic [7:0] REG_TOPOLOGY = 8'h85;
  localparam logic [7:0] REG_TARGET = 8'h8c;
  localparam logic [7:0] REG_REP_PRESENT = 8'h8d;
  localparam logic [7:0] REG_CHAN_KIND = 8'h8e;
  localparam logic [7:0] REG_IDX_SRC = 8'h8f;
  localparam logic [7:0] REG_CIPHER_EN = 8'h9f;
  localparam logic [7:0] REG_CIPHER_KEY = 8'ha0;
  localparam logic [7:0] REG_SLOT_LIMIT = 8'hdc;
  localparam logic [7:0] REG_MAX_POLL = 8'hdd;
  localparam logic [7:0] REG_ACCESS = 8'hf4;

  // host command opcodes
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_SAVE = 2'h2;

  // value codes
  localparam logic [7:0] PWR_3W = 8'h1e;
  localparam logic [7:0] PWR_5W = 8'h21;
  localparam logic [7:0] PWR_7W = 8'h23;
  localparam logic [7:0] PWR_10W = 8'h28;
  localparam logic [7:0] FRAME_8N1 = 8'h01;
  localparam logic [7:0] CHAN_SINGLE_ENDED = 8'h00;
  localparam logic [7:0] REP_POS_MIN = 8'h01;
  localparam logic [7:0] REP_POS_MAX = 8'hfe;
  localparam logic TOPO_P2MP = 1'b0;
  localparam logic TOPO_P2P = 1'b1;
  localparam logic [1:0] ACC_REQ_GRANT = 2'h0;
  localparam logic [1:0] ACC_TDMA = 2'h1;
  localparam logic [1:0] ACC_ADAPTIVE = 2'h2;
  localparam logic [1:0] ROLE_MASTER = 2'h0;
  localparam logic [1:0] ROLE_REPEATER = 2'h1;
  localparam logic [1:0] ROLE_SLAVE = 2'h2;

  typedef struct packed {
    logic [15:0] unit_id;
    logic [7:0] tx_power;
    logic [7:0] framing;
    logic [7:0] retrans;
    logic [7:0] rep_pos;
    logic [15:0] sync_addr;
    logic topo;
    logic [15:0] target;
    logic rep_present;
    logic [7:0] chan_kind;
    logic idx_src;
    logic cipher_en;
    logic [255:0] key;
    logic [1:0] access;
    logic [15:0] max_poll;
    logic [15:0] slot_limit;
  } rnc_cfg_t;

  localparam rnc_cfg_t CFG_RST = '{unit_id: 16'h0000, tx_power: PWR_10W, framing: FRAME_8N1,
    retrans: 8'h03, rep_pos: 8'h01, sync_addr: 16'h0000, topo: TOPO_P2P, target: 16'h0000,
    rep_present: 1'b0, chan_kind: CHAN_SINGLE_ENDED, idx_src: 1'b0, cipher_en: 1'b0,
    key: 256'h0, access: ACC_REQ_GRANT, max_poll: 16'h0006, slot_limit: 16'h000f};

  // per-identifier poll slot
  localparam int SLOT_MS = 20;
  localparam int CLK_KHZ = 250000;
  localparam int SLOT_CYCLES = SLOT_MS * CLK_KHZ;

endpackage

// ===== rnc_range_chk.sv
`timescale 1ns/100ps
module rnc_range_chk (
  // write under test
  input wire logic [7:0] reg_i,
  input wire logic [255:0] val_i,
  // pending context
  input wire logic topo_i,
  input wire logic [15:0] unit_id_i,
  // verdict
  output logic ok_o
);

  logic hi8_zero;
  logic hi16_zero;

  always_comb
  begin
    hi8_zero = (val_i[255:8] == 248'h0);
    hi16_zero = (val_i[255:16] == 240'h0);
    case (reg_i)
      rnc_pkg::REG_UNIT_ID, rnc_pkg::REG_SYNC_ADDR, rnc_pkg::REG_TARGET,
      rnc_pkg::REG_MAX_POLL, rnc_pkg::REG_SLOT_LIMIT: ok_o = hi16_zero;
      rnc_pkg::REG_TX_POWER: ok_o = hi8_zero && (val_i[7:0] == rnc_pkg::PWR_3W ||
        val_i[7:0] == rnc_pkg::PWR_5W || val_i[7:0] == rnc_pkg::PWR_7W || val_i[7:0] == rnc_pkg::PWR_10W);
      rnc_pkg::REG_FRAMING: ok_o = hi8_zero && val_i[7:0] == rnc_pkg::FRAME_8N1;
      rnc_pkg::REG_RETRANS: ok_o = hi8_zero;
      rnc_pkg::REG_REP_POS: ok_o = hi8_zero && val_i[7:0] >= rnc_pkg::REP_POS_MIN &&
        val_i[7:0] <= rnc_pkg::REP_POS_MAX;
      rnc_pkg::REG_TOPOLOGY, rnc_pkg::REG_IDX_SRC, rnc_pkg::REG_CIPHER_EN:
        ok_o = (val_i[255:1] == 255'h0);
      // auto-assigned identifiers forbid the repeater flag
      rnc_pkg::REG_REP_PRESENT: ok_o = (val_i[255:1] == 255'h0) &&
        !(val_i[0] && topo_i == rnc_pkg::TOPO_P2P && unit_id_i == 16'h0000);
      rnc_pkg::REG_CHAN_KIND: ok_o = hi8_zero && val_i[7:0] == rnc_pkg::CHAN_SINGLE_ENDED;
      rnc_pkg::REG_CIPHER_KEY: ok_o = 1'b1;
      rnc_pkg::REG_ACCESS: ok_o = (val_i[255:2] == 254'h0) && val_i[1:0] <= rnc_pkg::ACC_ADAPTIVE &&
        (val_i[1:0] == rnc_pkg::ACC_REQ_GRANT || topo_i == rnc_pkg::TOPO_P2MP);
      default: ok_o = 1'b0; // signal levels are read-only, unknown numbers refused
    endcase
  end

endmodule // rnc_range_chk

// ===== rnc_poll.sv
`timescale 1ns/100ps
module rnc_poll #(
  parameter int SLOT_CYC = rnc_pkg::SLOT_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // settings
  input wire logic en_i,
  input wire logic adaptive_i,
  input wire logic [15:0] own_i,
  input wire logic [15:0] max_i,
  input wire logic [15:0] limit_i,
  input wire logic [15:0] demand_i,
  // schedule
  output logic poll_valid_o,
  output logic [15:0] poll_id_o,
  output logic slot_start_o
);

  logic [31:0] timer_r;
  logic [15:0] used_r;
  logic [15:0] cap;
  logic tick;
  logic in_rng;

  assign tick = (timer_r == 32'(SLOT_CYC - 1));
  // adaptive share follows demand, capped, never below one slot
  assign cap = (demand_i < limit_i) ? demand_i : limit_i;
  // an id left over from an older own/max setting restarts the round
  assign in_rng = (poll_id_o > own_i) && (poll_id_o <= max_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !en_i || tick)
      timer_r <= 32'h0;
    else
      timer_r <= timer_r + 32'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      poll_valid_o <= 1'b0;
      poll_id_o <= 16'h0000;
      used_r <= 16'h0000;
      slot_start_o <= 1'b0;
    end
    else
    begin
      slot_start_o <= 1'b0;
      if (!en_i || max_i <= own_i)
        poll_valid_o <= 1'b0;
      else if (tick)
      begin
        slot_start_o <= 1'b1;
        poll_valid_o <= 1'b1;
        if (!poll_valid_o)
        begin
          poll_id_o <= 16'(own_i + 16'h0001);
          used_r <= 16'h0001;
        end
        else if (adaptive_i && used_r < cap && in_rng)
          used_r <= 16'(used_r + 16'h0001);
        else
        begin
          poll_id_o <= (!in_rng || poll_id_o == max_i) ? 16'(own_i + 16'h0001) : 16'(poll_id_o + 16'h0001);
          used_r <= 16'h0001;
        end
      end
    end
  end

  a_poll_range: assert property (@(posedge clk_i) disable iff (rst_i)
    slot_start_o && $stable(own_i) && $stable(max_i) |-> poll_id_o > own_i && poll_id_o <= max_i)
    else $error("polled id out of range");

  a_slot_cap: assert property (@(posedge clk_i) disable iff (rst_i)
    slot_start_o |-> used_r <= ((limit_i == 16'h0000) ? 16'h0001 : limit_i) || used_r == 16'h0001)
    else $error("adaptive slots exceed limit");

endmodule // rnc_poll

// ===== rnc_top.sv
`timescale 1ns/100ps
module rnc_top #(
  parameter int SLOT_CYC = rnc_pkg::SLOT_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // host command port
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic [7:0] cmd_reg_i,
  input wire logic [255:0] cmd_data_i,
  // host answer
  output logic rsp_valid_o,
  output logic rsp_ok_o,
  output logic [255:0] rsp_data_o,
  // node environment
  input wire logic [1:0] role_i,
  input wire logic [4:1] gpio_i,
  input wire logic [15:0] up_level_i,
  input wire logic [15:0] down_level_i,
  // channel access
  input wire logic data_pending_i,
  input wire logic grant_i,
  input wire logic [15:0] demand_i,
  output logic tx_request_o,
  output logic tx_allow_o,
  // applied configuration and derived settings
  output rnc_pkg::rnc_cfg_t cfg_o,
  output logic auto_id_o,
  output logic rep_index_active_o,
  output logic [7:0] repeater_num_o,
  output logic repeater_present_o,
  output logic [8:0] attempt_limit_o,
  // master poll schedule
  output logic poll_valid_o,
  output logic [15:0] poll_id_o,
  output logic slot_start_o
);

  rnc_pkg::rnc_cfg_t pending_r;
  logic write_ok;
  logic is_write;
  logic is_save;
  logic is_read;
  logic [255:0] read_val;
  logic poll_en_r;

  assign is_write = cmd_valid_i && cmd_op_i == rnc_pkg::OP_WRITE;
  assign is_save = cmd_valid_i && cmd_op_i == rnc_pkg::OP_SAVE;
  assign is_read = cmd_valid_i && cmd_op_i == rnc_pkg::OP_READ;

  rnc_range_chk u_chk (
    .reg_i(cmd_reg_i),
    .val_i(cmd_data_i),
    .topo_i(pending_r.topo),
    .unit_id_i(pending_r.unit_id),
    .ok_o(write_ok)
  );

  // pending table: what the host edits and reads back
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pending_r <= rnc_pkg::CFG_RST;
    else if (is_write && write_ok)
    begin
      case (cmd_reg_i)
        rnc_pkg::REG_UNIT_ID: pending_r.unit_id <= cmd_data_i[15:0];
        rnc_pkg::REG_TX_POWER: pending_r.tx_power <= cmd_data_i[7:0];
        rnc_pkg::REG_FRAMING: pending_r.framing <= cmd_data_i[7:0];
        rnc_pkg::REG_RETRANS: pending_r.retrans <= cmd_data_i[7:0];
        rnc_pkg::REG_REP_POS: pending_r.rep_pos <= cmd_data_i[7:0];
        rnc_pkg::REG_SYNC_ADDR: pending_r.sync_addr <= cmd_data_i[15:0];
        rnc_pkg::REG_TOPOLOGY: pending_r.topo <= cmd_data_i[0];
        rnc_pkg::REG_TARGET: pending_r.target <= cmd_data_i[15:0];
        rnc_pkg::REG_REP_PRESENT: pending_r.rep_present <= cmd_data_i[0];
        rnc_pkg::REG_CHAN_KIND: pending_r.chan_kind <= cmd_data_i[7:0];
        rnc_pkg::REG_IDX_SRC: pending_r.idx_src <= cmd_data_i[0];
        rnc_pkg::REG_CIPHER_EN: pending_r.cipher_en <= cmd_data_i[0];
        rnc_pkg::REG_CIPHER_KEY: pending_r.key <= cmd_data_i;
        rnc_pkg::REG_ACCESS: pending_r.access <= cmd_data_i[1:0];
        rnc_pkg::REG_MAX_POLL: pending_r.max_poll <= cmd_data_i[15:0];
        rnc_pkg::REG_SLOT_LIMIT: pending_r.slot_limit <= cmd_data_i[15:0];
        default: pending_r <= pending_r;
      endcase
    end
  end

  // applied table: changes only on save, so a half-edited set never runs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_o <= rnc_pkg::CFG_RST;
    else if (is_save)
      cfg_o <= pending_r;
  end

  always_comb
  begin
    read_val = 256'h0;
    case (cmd_reg_i)
      rnc_pkg::REG_UNIT_ID: read_val = {240'h0, pending_r.unit_id};
      rnc_pkg::REG_TX_POWER: read_val = {248'h0, pending_r.tx_power};
      rnc_pkg::REG_FRAMING: read_val = {248'h0, pending_r.framing};
      rnc_pkg::REG_RETRANS: read_val = {248'h0, pending_r.retrans};
      rnc_pkg::REG_REP_POS: read_val = {248'h0, pending_r.rep_pos};
      rnc_pkg::REG_SYNC_ADDR: read_val = {240'h0, pending_r.sync_addr};
      // levels pass through as signed 16-bit dBm, sign-extended
      rnc_pkg::REG_UP_LEVEL: read_val = {{240{up_level_i[15]}}, up_level_i};
      rnc_pkg::REG_DOWN_LEVEL: read_val = {{240{down_level_i[15]}}, down_level_i};
      rnc_pkg::REG_TOPOLOGY: read_val = {255'h0, pending_r.topo};
      rnc_pkg::REG_TARGET: read_val = {240'h0, pending_r.target};
      rnc_pkg::REG_REP_PRESENT: read_val = {255'h0, pending_r.rep_present};
      rnc_pkg::REG_CHAN_KIND: read_val = {248'h0, pending_r.chan_kind};
      rnc_pkg::REG_IDX_SRC: read_val = {255'h0, pending_r.idx_src};
      rnc_pkg::REG_CIPHER_EN: read_val = {255'h0, pending_r.cipher_en};
      rnc_pkg::REG_CIPHER_KEY: read_val = pending_r.key;
      rnc_pkg::REG_ACCESS: read_val = {254'h0, pending_r.access};
      rnc_pkg::REG_MAX_POLL: read_val = {240'h0, pending_r.max_poll};
      rnc_pkg::REG_SLOT_LIMIT: read_val = {240'h0, pending_r.slot_limit};
      default: read_val = 256'h0;
    endcase
  end

  // one answer per command, one cycle later
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rsp_valid_o <= 1'b0;
      rsp_ok_o <= 1'b0;
      rsp_data_o <= 256'h0;
    end
    else
    begin
      rsp_valid_o <= cmd_valid_i;
      rsp_data_o <= 256'h0;
      if (is_write)
        rsp_ok_o <= write_ok;
      else if (is_save)
        rsp_ok_o <= 1'b1;
      else if (is_read)
      begin
        rsp_ok_o <= (read_val != 256'h0) || (cmd_reg_i == rnc_pkg::REG_UNIT_ID) ||
          (cmd_reg_i >= rnc_pkg::REG_UNIT_ID && cmd_reg_i <= rnc_pkg::REG_ACCESS);
        rsp_data_o <= read_val;
      end
      else
        rsp_ok_o <= 1'b0;
    end
  end

  // derived settings from the applied table
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      auto_id_o <= 1'b0;
      rep_index_active_o <= 1'b0;
      repeater_num_o <= 8'h01;
      repeater_present_o <= 1'b0;
      attempt_limit_o <= 9'h004;
      poll_en_r <= 1'b0;
    end
    else
    begin
      auto_id_o <= cfg_o.topo == rnc_pkg::TOPO_P2P && cfg_o.unit_id == 16'h0000;
      rep_index_active_o <= role_i == rnc_pkg::ROLE_REPEATER &&
        (cfg_o.topo == rnc_pkg::TOPO_P2MP || cfg_o.unit_id == 16'h0000);
      repeater_num_o <= cfg_o.idx_src ? {4'h0, gpio_i} + 8'h01 : cfg_o.rep_pos;
      repeater_present_o <= role_i == rnc_pkg::ROLE_MASTER && cfg_o.rep_present;
      attempt_limit_o <= {1'b0, cfg_o.retrans} + 9'h001;
      poll_en_r <= role_i == rnc_pkg::ROLE_MASTER && cfg_o.topo == rnc_pkg::TOPO_P2MP &&
        cfg_o.access != rnc_pkg::ACC_REQ_GRANT;
    end
  end

  // slave side of request/grant; a grant without an open request is ignored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_request_o <= 1'b0;
      tx_allow_o <= 1'b0;
    end
    else if (role_i != rnc_pkg::ROLE_SLAVE || cfg_o.access != rnc_pkg::ACC_REQ_GRANT || !data_pending_i)
    begin
      tx_request_o <= 1'b0;
      tx_allow_o <= 1'b0;
    end
    else if (!tx_allow_o)
    begin
      tx_request_o <= 1'b1;
      tx_allow_o <= tx_request_o && grant_i;
    end
  end

  rnc_poll #(
    .SLOT_CYC(SLOT_CYC)
  ) u_poll (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(poll_en_r),
    .adaptive_i(cfg_o.access == rnc_pkg::ACC_ADAPTIVE),
    .own_i(cfg_o.unit_id),
    .max_i(cfg_o.max_poll),
    .limit_i(cfg_o.slot_limit),
    .demand_i(demand_i),
    .poll_valid_o(poll_valid_o),
    .poll_id_o(poll_id_o),
    .slot_start_o(slot_start_o)
  );

  sequence s_save;
    cmd_valid_i && cmd_op_i == rnc_pkg::OP_SAVE;
  endsequence

  sequence s_bad_write;
    cmd_valid_i && cmd_op_i == rnc_pkg::OP_WRITE && !write_ok;
  endsequence

  a_save_applies: assert property (@(posedge clk_i) disable iff (rst_i)
    s_save |=> cfg_o == $past(pending_r))
    else $error("save did not apply pending table");

  a_hold_unsaved: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cmd_valid_i && cmd_op_i == rnc_pkg::OP_SAVE) |=> $stable(cfg_o))
    else $error("applied table changed without save");

  a_bad_write_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bad_write |=> $stable(pending_r) && rsp_valid_o && !rsp_ok_o)
    else $error("refused write altered table");

  a_level_ro: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_op_i == rnc_pkg::OP_WRITE && cmd_reg_i == rnc_pkg::REG_UP_LEVEL |=> !rsp_ok_o)
    else $error("signal level write accepted");

  a_tdma_p2p: assert property (@(posedge clk_i) disable iff (rst_i)
    is_write && cmd_reg_i == rnc_pkg::REG_ACCESS && cmd_data_i[1:0] != 2'h0 && pending_r.topo
    |=> !rsp_ok_o && $stable(pending_r.access))
    else $error("tdma accepted on point-to-point");

  a_power_codes: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_o.tx_power == rnc_pkg::PWR_3W || cfg_o.tx_power == rnc_pkg::PWR_5W ||
    cfg_o.tx_power == rnc_pkg::PWR_7W || cfg_o.tx_power == rnc_pkg::PWR_10W)
    else $error("illegal power code applied");

  a_auto_id: assert property (@(posedge clk_i) disable iff (rst_i)
    $stable(cfg_o) ##1 $stable(cfg_o) |-> auto_id_o == (cfg_o.topo && cfg_o.unit_id == 16'h0000))
    else $error("automatic identifier flag wrong");

  a_rep_number: assert property (@(posedge clk_i) disable iff (rst_i)
    $stable(cfg_o) && $stable(gpio_i) |-> repeater_num_o >= 8'h01 &&
    repeater_num_o == (cfg_o.idx_src ? {4'h0, gpio_i} + 8'h01 : cfg_o.rep_pos))
    else $error("repeater number wrong");

  a_grant_order: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(tx_allow_o) |-> $past(tx_request_o) && $past(grant_i))
    else $error("transmit allowed before grant");

  a_attempts: assert property (@(posedge clk_i) disable iff (rst_i)
    $stable(cfg_o) |=> attempt_limit_o == {1'b0, $past(cfg_o.retrans)} + 9'h001)
    else $error("attempt limit not retrans plus one");

  sequence s_good_power;
    is_write && write_ok && cmd_reg_i == rnc_pkg::REG_TX_POWER;
  endsequence

  a_power_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    s_good_power |=> pending_r.tx_power == $past(cmd_data_i[7:0]) && rsp_valid_o && rsp_ok_o)
    else $error("accepted power write lost");

  a_save_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    s_save |=> rsp_valid_o && rsp_ok_o && rsp_data_o == 256'h0)
    else $error("save not acknowledged");

  a_framing_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_o.framing == rnc_pkg::FRAME_8N1 && pending_r.framing == rnc_pkg::FRAME_8N1)
    else $error("framing not eight-none-one");

  a_chan_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_o.chan_kind == rnc_pkg::CHAN_SINGLE_ENDED)
    else $error("serial channel kind not single-ended");

  a_rep_pos_range: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_o.rep_pos >= rnc_pkg::REP_POS_MIN && cfg_o.rep_pos <= rnc_pkg::REP_POS_MAX)
    else $error("repeater position out of range");

  a_access_code: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_o.access != 2'h3 && pending_r.access != 2'h3)
    else $error("undefined access code held");

  a_flag_master: assert property (@(posedge clk_i) disable iff (rst_i)
    repeater_present_o |-> $past(role_i) == rnc_pkg::ROLE_MASTER && $past(cfg_o.rep_present))
    else $error("repeater flag outside master");

  a_allow_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_allow_o |-> $past(data_pending_i) && $past(role_i) == rnc_pkg::ROLE_SLAVE)
    else $error("transmit allowed without pending data");

  a_key_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    is_read && cmd_reg_i == rnc_pkg::REG_CIPHER_KEY |=> rsp_valid_o && rsp_data_o == $past(pending_r.key))
    else $error("key read back wrong");

  a_unit_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
    is_write && cmd_reg_i == rnc_pkg::REG_UNIT_ID && cmd_data_i[255:16] != 240'h0
    |=> !rsp_ok_o && $stable(pending_r.unit_id))
    else $error("oversized identifier accepted");

  a_index_active: assert property (@(posedge clk_i) disable iff (rst_i)
    rep_index_active_o |-> $past(role_i) == rnc_pkg::ROLE_REPEATER)
    else $error("repeater index active off a repeater");

  a_poll_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    poll_valid_o |-> $past(cfg_o.access, 2) != rnc_pkg::ACC_REQ_GRANT &&
    $past(cfg_o.topo, 2) == rnc_pkg::TOPO_P2MP)
    else $error("polling outside tdma on point-to-multipoint");

  a_refuse_op: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_valid_i && cmd_op_i == 2'h3 |=> rsp_valid_o && !rsp_ok_o && $stable(pending_r) && $stable(cfg_o))
    else $error("unknown command had an effect");

endmodule // rnc_top

// ===== rnc_host_model.sv
`timescale 1ns/100ps
module rnc_host_model (
  // clock
  input wire logic clk_i,
  // command out
  output logic cmd_valid_o,
  output logic [1:0] cmd_op_o,
  output logic [7:0] cmd_reg_o,
  output logic [255:0] cmd_data_o,
  // answer in
  input wire logic rsp_valid_i,
  input wire logic rsp_ok_i,
  input wire logic [255:0] rsp_data_i
);
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_op_o = 2'h0;
    cmd_reg_o = 8'h00;
    cmd_data_o = '0;
  end

  // request held over the taking edge; answer is read half a cycle after it
  task automatic xfer(input logic [1:0] op, input logic [7:0] rg, input logic [255:0] d,
    output logic v, output logic ok, output logic [255:0] q);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_op_o = op;
    cmd_reg_o = rg;
    cmd_data_o = d;
    @(posedge clk_i);
    @(negedge clk_i);
    v = rsp_valid_i;
    ok = rsp_ok_i;
    q = rsp_data_i;
    // released register and data lines show no stale value
    cmd_valid_o = 1'b0;
    cmd_reg_o = ~rg;
    cmd_data_o = ~d;
  endtask
endmodule // rnc_host_model

// ===== test_rnc_top.sv
`timescale 1ns/100ps
module test_rnc_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] role_i = 2'h2;
  logic [4:1] gpio_i = 4'hf;
  logic [15:0] up_level_i = 16'hff01;
  logic [15:0] down_level_i = 16'hff9c;
  logic data_pending_i = 1'b0;
  logic grant_i = 1'b0;
  logic [15:0] demand_i = 16'h0001;
  logic cmd_valid;
  logic [1:0] cmd_op;
  logic [7:0] cmd_reg;
  logic [255:0] cmd_data;
  logic rsp_valid;
  logic rsp_ok;
  logic [255:0] rsp_data;
  logic tx_request;
  logic tx_allow;
  rnc_pkg::rnc_cfg_t cfg;
  logic auto_id;
  logic rep_act;
  logic [7:0] rep_num;
  logic rep_present;
  logic [8:0] att;
  logic poll_valid;
  logic [15:0] poll_id;
  logic slot_start;
  int fails = 0;
  int n_checks = 0;
  int t0;
  logic v;
  logic ok;
  logic [255:0] q;
  logic [7:0] rst_reg [16] = '{8'h69, 8'h6c, 8'h6e, 8'h71, 8'h72, 8'h76, 8'h85, 8'h8c, 8'h8d, 8'h8e, 8'h8f,
    8'h9f, 8'ha0, 8'hf4, 8'hdd, 8'hdc};
  logic [15:0] rst_val [16] = '{16'h0, 16'h28, 16'h1, 16'h3, 16'h1, 16'h0, 16'h1, 16'h0, 16'h0, 16'h0, 16'h0,
    16'h0, 16'h0, 16'h0, 16'h6, 16'hf};
  logic [7:0] pw [4] = '{8'h1e, 8'h21, 8'h23, 8'h28};

  // short slot so the poll schedule fits the run
  rnc_top #(.SLOT_CYC(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op),
    .cmd_reg_i(cmd_reg), .cmd_data_i(cmd_data), .rsp_valid_o(rsp_valid), .rsp_ok_o(rsp_ok),
    .rsp_data_o(rsp_data), .role_i(role_i), .gpio_i(gpio_i), .up_level_i(up_level_i),
    .down_level_i(down_level_i), .data_pending_i(data_pending_i), .grant_i(grant_i), .demand_i(demand_i),
    .tx_request_o(tx_request), .tx_allow_o(tx_allow), .cfg_o(cfg), .auto_id_o(auto_id),
    .rep_index_active_o(rep_act), .repeater_num_o(rep_num), .repeater_present_o(rep_present),
    .attempt_limit_o(att), .poll_valid_o(poll_valid), .poll_id_o(poll_id), .slot_start_o(slot_start));

  rnc_host_model host_u (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op), .cmd_reg_o(cmd_reg),
    .cmd_data_o(cmd_data), .rsp_valid_i(rsp_valid), .rsp_ok_i(rsp_ok), .rsp_data_i(rsp_data));

  always #2 clk_i = ~clk_i;

  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input logic [1:0] op, input logic [7:0] rg, input logic [255:0] d, input logic eok,
    input logic [255:0] exp);
    host_u.xfer(op, rg, d, v, ok, q);
    check(v, 1'b1);
    check(ok, eok);
    check(q, exp);
  endtask

  task automatic wr(input logic [7:0] rg, input logic [255:0] d, input logic eok);
    cmd(rnc_pkg::OP_WRITE, rg, d, eok, '0);
  endtask

  task automatic rd(input logic [7:0] rg, input logic [255:0] exp);
    cmd(rnc_pkg::OP_READ, rg, '0, 1'b1, exp);
  endtask

  // derived outputs settle one cycle, the poll schedule two cycles, after the save is taken
  task automatic save;
    cmd(rnc_pkg::OP_SAVE, 8'h00, '0, 1'b1, '0);
    repeat (2) @(negedge clk_i);
  endtask

  // leaves t0 at the cycles waited for the next slot pulse
  task automatic next_slot;
    t0 = 0;
    do
    begin
      @(negedge clk_i);
      t0++;
    end while (slot_start !== 1'b1 && t0 < 100);
  endtask

  task final_report;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    fails++;
    final_report;
  end

  initial
  begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check({255'h0, cfg === rnc_pkg::CFG_RST}, 256'h1);
    check(att, 9'h004);
    check(auto_id, 1'b1);
    for (int i = 0; i < 16; i++)
      rd(rst_reg[i], rst_val[i]);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h6c, pw[i], 1'b1);
      rd(8'h6c, pw[i]);
    end
    wr(8'h6c, 8'h1f, 1'b0);
    rd(8'h6c, 8'h28);
    wr(8'h6e, 8'h02, 1'b0);
    wr(8'h8e, 8'h01, 1'b0);
    wr(8'h69, 256'h10000, 1'b0);
    wr(8'h7b, 8'h00, 1'b0);
    rd(8'h7b, {{240{1'b1}}, 16'hff01});
    rd(8'h7c, {{240{1'b1}}, 16'hff9c});
    wr(8'h8d, 1'b1, 1'b0);
    wr(8'hf4, 2'h1, 1'b0);
    cmd(2'h3, 8'h69, '0, 1'b0, '0);
    wr(8'h71, 8'hff, 1'b1);
    check(att, 9'h004);
    save;
    check(att, 9'h100);
    role_i = rnc_pkg::ROLE_REPEATER;
    wr(8'h8f, 1'b1, 1'b1);
    save;
    check(rep_num, 8'h10);
    wr(8'h72, 8'h00, 1'b0);
    wr(8'h72, 8'hff, 1'b0);
    // positions climb from the master toward the slave end
    wr(8'h72, 8'h02, 1'b1);
    wr(8'h72, 8'hfe, 1'b1);
    wr(8'h8f, 1'b0, 1'b1);
    save;
    check(rep_num, 8'hfe);
    check(rep_act, 1'b1);
    role_i = rnc_pkg::ROLE_MASTER;
    repeat (2) @(negedge clk_i);
    check(rep_act, 1'b0);
    wr(8'ha0, {8{32'hc3a50f96}}, 1'b1);
    rd(8'ha0, {8{32'hc3a50f96}});
    wr(8'h9f, 2'h2, 1'b0);
    wr(8'h9f, 1'b1, 1'b1);
    // slave asks before it may send; a stray grant does nothing
    role_i = rnc_pkg::ROLE_SLAVE;
    grant_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check(tx_allow, 1'b0);
    grant_i = 1'b0;
    data_pending_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check(tx_request, 1'b1);
    check(tx_allow, 1'b0);
    grant_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check(tx_allow, 1'b1);
    data_pending_i = 1'b0;
    grant_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check(tx_request | tx_allow, 1'b0);
    wr(8'h69, 16'h0001, 1'b1);
    wr(8'h85, 1'b0, 1'b1);
    wr(8'h8c, 16'h0000, 1'b1);
    wr(8'hdd, 16'h0003, 1'b1);
    wr(8'hf4, 2'h2, 1'b1);
    wr(8'hf4, 2'h3, 1'b0);
    wr(8'hf4, 2'h1, 1'b1);
    wr(8'h8d, 1'b1, 1'b1);
    role_i = rnc_pkg::ROLE_MASTER;
    save;
    check(rep_present, 1'b1);
    check(auto_id, 1'b0);
    // own id 1, max 3: fixed slots walk 2, 3, 2, 3
    for (int i = 0; i < 4; i++)
    begin
      next_slot;
      check(poll_valid, 1'b1);
      check(poll_id, (i % 2 == 0) ? 16'h2 : 16'h3);
      if (i > 0)
        check(t0, 8);
    end
    // stop polling, then restart adaptive with demand and limit both two
    role_i = rnc_pkg::ROLE_SLAVE;
    wr(8'hf4, 2'h2, 1'b1);
    wr(8'hdc, 16'h0002, 1'b1);
    demand_i = 16'h0002;
    save;
    check(poll_valid, 1'b0);
    role_i = rnc_pkg::ROLE_MASTER;
    for (int i = 0; i < 6; i++)
    begin
      next_slot;
      check(poll_id, (i % 4 < 2) ? 16'h2 : 16'h3);
      if (i > 0)
        check(t0, 8);
    end
    final_report;
  end
endmodule // test_rnc_top
